// ---- include/usp_pkg.sv ----
// ----------------------------------------------------------------
// Serial port constants and carriers
// ----------------------------------------------------------------
package usp_pkg;

  // Register indices; byte address is four times the index
  localparam int           ADDR_W                  = 12;
  localparam logic [7:0]   IDX_SERIAL_CONTROL      = 8'h98;
  localparam logic [7:0]   IDX_SERIAL_BUFFER       = 8'h99;
  localparam logic [7:0]   IDX_BAUD_RELOAD         = 8'h9a;
  localparam logic [7:0]   IDX_BAUD_CONTROL        = 8'h9b;
  localparam logic [7:0]   IDX_POWER_CONTROL       = 8'h9c;
  localparam logic [7:0]   IDX_SLAVE_ADDRESS       = 8'ha9;
  localparam logic [7:0]   IDX_SLAVE_ADDRESS_MASK  = 8'hb9;

  // Field positions of serial_control
  localparam int           SC_FE_SM0               = 7;
  localparam int           SC_SM1                  = 6;
  localparam int           SC_MPE                  = 5;
  localparam int           SC_REN                  = 4;
  localparam int           SC_TB8                  = 3;
  localparam int           SC_RB8                  = 2;
  localparam int           SC_TI                   = 1;
  localparam int           SC_RI                   = 0;
  // Field positions of baud_control and power_control_reg
  localparam int           BC_RUN                  = 4;
  localparam int           BC_TXSEL                = 3;
  localparam int           BC_RXSEL                = 2;
  localparam int           BC_SPD                  = 1;
  localparam int           BC_SHIFT_MODE_CLOCK_SELECT                = 0;
  localparam int           PC_DOUBLER              = 7;
  localparam int           PC_FEACC                = 6;

  // Reset values
  localparam logic [7:0]   SERIAL_CONTROL_RST      = 8'h00;
  localparam logic [7:0]   SERIAL_BUFFER_RST       = 8'h00;
  localparam logic [7:0]   BAUD_RELOAD_RST         = 8'h00;
  localparam logic [4:0]   BAUD_CONTROL_RST        = 5'h00;
  localparam logic [1:0]   POWER_CONTROL_RST       = 2'h0;
  localparam logic [7:0]   SLAVE_ADDRESS_RST       = 8'h00;
  localparam logic [7:0]   SLAVE_ADDRESS_MASK_RST  = 8'h00;

  // Timing counts
  localparam logic [2:0]   BRG_PRESCALE_LAST       = 3'h5;
  localparam logic [1:0]   M0_FIX_HALF_LAST        = 2'h2;
  localparam logic [3:0]   M0_BRG_HALF_LAST        = 4'h7;
  localparam logic [3:0]   SMP_LAST                = 4'hf;
  localparam logic [3:0]   SMP_MID                 = 4'h7;
  localparam logic [3:0]   FRAME8_BITS             = 4'ha;
  localparam logic [3:0]   FRAME9_BITS             = 4'hb;
  localparam logic [3:0]   SHIFT_BITS              = 4'h8;
  localparam logic [3:0]   RX_LAST_SHORT           = 4'h8;
  localparam logic [3:0]   RX_LAST_LONG            = 4'h9;

  // Operating modes
  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART8 = 2'b01,
    MODE_UART9 = 2'b10,
    MODE_VAR9  = 2'b11
  } usp_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_ASYNC = 2'b01,
    TX_SHIFT = 2'b10
  } usp_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10,
    RX_DONE  = 2'b11
  } usp_rx_st_t;

  // APB carriers
  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } usp_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } usp_apb_rsp_t;

endpackage : usp_pkg

// ---- verilog/usp_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Two-flop synchroniser for the receive pin
// ----------------------------------------------------------------
module usp_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Level in and out
  input  wire logic din,
  output logic      dout
);
  import usp_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } usp_sync_t;

  usp_sync_t r;
  usp_sync_t n;

  // First stage feeds only the second
  always_comb begin
    n    = r;
    n.s1 = din;
    n.s2 = r.s1;
  end

  // Idle line is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= 2'b11;
    end else begin
      r <= n;
    end
  end

  assign dout = r.s2;

endmodule : usp_sync
`default_nettype wire

// ---- verilog/usp_brg.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Internal baud-rate generator: prescaler and reload counter
// ----------------------------------------------------------------
module usp_brg (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       run,
  input  wire logic       fast,
  input  wire logic [7:0] reload,
  // Overflow pulse
  output logic            ovf
);
  import usp_pkg::*;

  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] cnt;
    logic       ovf;
  } usp_brg_t;

  usp_brg_t r;
  usp_brg_t n;

  // Counter holds its value while stopped
  always_comb begin
    n     = r;
    n.ovf = 1'b0;
    if (run) begin
      n.pre = (r.pre == BRG_PRESCALE_LAST) ? 3'h0 : r.pre + 3'h1;
      if (fast || r.pre == BRG_PRESCALE_LAST) begin
        if (r.cnt == 8'hff) begin
          n.cnt = reload;
          n.ovf = 1'b1;
        end else begin
          n.cnt = r.cnt + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ovf = r.ovf;

endmodule : usp_brg
`default_nettype wire

// ---- verilog/usp_uart.sv ----
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Bad stop bit sets sticky framing flag
// - Control bit 7 is framing flag or mode
// - Two mode bits pick one of four modes
// - Multiprocessor enable filters frames, modes 1-3
// - Reception only while receive enable set
// - Ninth transmitted bit from tx_ninth_bit
// - rx_ninth_bit gets ninth or stop bit
// - tx_done_flag at eighth bit or stop start
// - rx_done_flag on end of reception
// - Baud generator counts only while running
// - Modes 1 and 3 transmit clock from timer or generator
// - Modes 1 and 3 receive clock from timer or generator
// - Speed select picks slow or fast prescale
// - Mode 0 clock: divide-by-six or generator
// - Baud control upper bits read zero
// - Mode 1 frames are ten bits
// - Modes 2 and 3 frames are eleven bits
// - Framing check moves done flag to stop
// - Mode 2 rate is clock/16 or clock/32
module usp_uart (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // Register bus
  input  wire usp_pkg::usp_apb_req_t apb_req,
  output var  usp_pkg::usp_apb_rsp_t apb_rsp,
  // Timer 1 overflow pulse, same clock
  input  wire logic                  t1_ovf,
  // Serial lines
  output logic                       txd,
  input  wire logic                  rxd_in,
  output logic                       rxd_out,
  output logic                       rxd_oe_n
);
  import usp_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    usp_apb_rsp_t rsp;
    logic         sm0;
    logic         sm1;
    logic         mpe;
    logic         ren;
    logic         tb8;
    logic         rb8;
    logic         ti;
    logic         ri;
    logic         fe;
    logic [7:0]   rx_buf;
    logic [7:0]   baud_reload;
    logic [4:0]   bc;
    logic         dbl;
    logic         feacc;
    logic [7:0]   slave_address;
    logic [7:0]   slave_address_mask;
    logic         half_clk;
    logic         half_brg;
    logic         half_t1;
    logic [1:0]   div3;
    usp_tx_st_t   tx_st;
    logic [10:0]  tx_sh;
    logic [3:0]   tx_bits;
    logic [3:0]   tx_cnt;
    logic         m0_rx;
    logic         m0_hi;
    logic         txd;
    logic         rxd_out;
    logic         rxd_oe_n;
    usp_rx_st_t   rx_st;
    logic [3:0]   rx_cnt;
    logic [3:0]   rx_bits;
    logic [9:0]   rx_sh;
    logic         rxd_prev;
  } usp_state_t;

  usp_state_t r;
  usp_state_t n;
  logic       rxd_s;
  logic       brg_ovf;

  // Address decode shared by read and write paths
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction : hit

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  usp_sync u_rxd_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (rxd_in),
    .dout    (rxd_s)
  );

  usp_brg u_brg (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (r.bc[BC_RUN]),
    .fast    (r.bc[BC_SPD]),
    .reload  (r.baud_reload),
    .ovf     (brg_ovf)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0]        mode;
    logic              m0;
    logic              wr;
    logic              sb_wr;
    logic [ADDR_W-1:0] a;
    logic [7:0]        w;
    logic [7:0]        rdat;
    logic              fix_smp;
    logic              brg_smp;
    logic              t1_smp;
    logic              tx_smp;
    logic              rx_smp;
    logic              m0_tick;
    logic [3:0]        m0_lim;
    logic [3:0]        rx_last;
    logic              stop_b;
    logic              addr_ok;
    logic              accept;
    mode    = 2'b00;
    m0      = 1'b0;
    wr      = 1'b0;
    sb_wr   = 1'b0;
    a       = apb_req.paddr;
    w       = apb_req.pwdata[7:0];
    rdat    = 8'h00;
    fix_smp = 1'b0;
    brg_smp = 1'b0;
    t1_smp  = 1'b0;
    tx_smp  = 1'b0;
    rx_smp  = 1'b0;
    m0_tick = 1'b0;
    m0_lim  = 4'h0;
    rx_last = 4'h0;
    stop_b  = 1'b0;
    addr_ok = 1'b0;
    accept  = 1'b0;
    n       = r;

    // Mode decode
    mode = {r.sm0, r.sm1};
    m0   = (mode == MODE_SHIFT);

    // Sample ticks; doubler skips the halving stage
    n.half_clk = ~r.half_clk;
    n.half_brg = r.half_brg ^ brg_ovf;
    n.half_t1  = r.half_t1 ^ t1_ovf;
    fix_smp    = r.dbl | r.half_clk;
    brg_smp    = brg_ovf & (r.dbl | r.half_brg);
    t1_smp     = t1_ovf & (r.dbl | r.half_t1);
    tx_smp     = (mode == MODE_UART9) ? fix_smp : (r.bc[BC_TXSEL] ? brg_smp : t1_smp);
    rx_smp     = (mode == MODE_UART9) ? fix_smp : (r.bc[BC_RXSEL] ? brg_smp : t1_smp);

    // Mode 0 half-bit ticks: three clocks each, or eight generator samples
    n.div3  = (r.div3 == M0_FIX_HALF_LAST) ? 2'h0 : r.div3 + 2'h1;
    m0_tick = r.bc[BC_SHIFT_MODE_CLOCK_SELECT] ? brg_smp : (r.div3 == M0_FIX_HALF_LAST);
    m0_lim  = r.bc[BC_SHIFT_MODE_CLOCK_SELECT] ? M0_BRG_HALF_LAST : 4'h0;

    // ----------------------------------------------------------------
    // APB slave: answer in the first access cycle, no wait states
    // ----------------------------------------------------------------
    n.rsp.pready  = apb_req.psel & ~apb_req.penable;
    n.rsp.pslverr = 1'b0;
    n.rsp.prdata  = 32'h0000_0000;
    if (apb_req.psel && !apb_req.penable) begin
      if (hit(a, IDX_SERIAL_CONTROL)) begin
        rdat = {r.feacc ? r.fe : r.sm0, r.sm1, r.mpe, r.ren,
                r.tb8, r.rb8, r.ti, r.ri};
      end else if (hit(a, IDX_SERIAL_BUFFER)) begin
        rdat = r.rx_buf;
      end else if (hit(a, IDX_BAUD_RELOAD)) begin
        rdat = r.baud_reload;
      end else if (hit(a, IDX_BAUD_CONTROL)) begin
        rdat = {3'b000, r.bc};
      end else if (hit(a, IDX_POWER_CONTROL)) begin
        rdat = {r.dbl, r.feacc, 6'h00};
      end else if (hit(a, IDX_SLAVE_ADDRESS)) begin
        rdat = r.slave_address;
      end else if (hit(a, IDX_SLAVE_ADDRESS_MASK)) begin
        rdat = r.slave_address_mask;
      end else begin
        n.rsp.pslverr = 1'b1;
      end
      n.rsp.prdata = {24'h00_0000, rdat};
    end

    // Writes land at the access edge; engines below may override flags
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite & r.rsp.pready;
    if (wr) begin
      if (hit(a, IDX_SERIAL_CONTROL)) begin
        if (r.feacc) begin
          n.fe = w[SC_FE_SM0];
        end else begin
          n.sm0 = w[SC_FE_SM0];
        end
        n.sm1 = w[SC_SM1];
        n.mpe = w[SC_MPE];
        n.ren = w[SC_REN];
        n.tb8 = w[SC_TB8];
        n.rb8 = w[SC_RB8];
        n.ti  = w[SC_TI];
        n.ri  = w[SC_RI];
      end else if (hit(a, IDX_SERIAL_BUFFER)) begin
        sb_wr = 1'b1;
      end else if (hit(a, IDX_BAUD_RELOAD)) begin
        n.baud_reload = w;
      end else if (hit(a, IDX_BAUD_CONTROL)) begin
        n.bc = w[4:0];
      end else if (hit(a, IDX_POWER_CONTROL)) begin
        n.dbl   = w[PC_DOUBLER];
        n.feacc = w[PC_FEACC];
      end else if (hit(a, IDX_SLAVE_ADDRESS)) begin
        n.slave_address = w;
      end else if (hit(a, IDX_SLAVE_ADDRESS_MASK)) begin
        n.slave_address_mask = w;
      end
    end

    // ----------------------------------------------------------------
    // Transmitter and mode 0 shifter
    // ----------------------------------------------------------------
    // A buffer write while busy is dropped rather than corrupting a frame
    case (r.tx_st)
      TX_IDLE: begin
        n.tx_cnt = 4'h0;
        n.div3   = 2'h0;  // Restart divider: first low half is full
        n.m0_hi  = 1'b0;
        if (sb_wr && m0) begin
          n.tx_st    = TX_SHIFT;
          n.m0_rx    = 1'b0;
          n.tx_sh    = {3'b111, w};
          n.tx_bits  = SHIFT_BITS;
          n.txd      = 1'b0;
          n.rxd_out  = w[0];
          n.rxd_oe_n = 1'b0;
        end else if (sb_wr) begin
          n.tx_st   = TX_ASYNC;
          n.tx_sh   = {1'b1, (mode == MODE_UART8) ? 1'b1 : r.tb8, w, 1'b0};
          n.tx_bits = (mode == MODE_UART8) ? FRAME8_BITS : FRAME9_BITS;
          n.txd     = 1'b0;
        end else if (m0 && r.ren && !r.ri) begin
          n.tx_st    = TX_SHIFT;
          n.m0_rx    = 1'b1;
          n.tx_sh    = 11'h000;
          n.tx_bits  = SHIFT_BITS;
          n.txd      = 1'b0;
          n.rxd_oe_n = 1'b1;
        end
      end
      TX_ASYNC: begin
        if (tx_smp) begin
          n.tx_cnt = r.tx_cnt + 4'h1;
          if (r.tx_cnt == SMP_LAST) begin
            n.tx_sh   = {1'b1, r.tx_sh[10:1]};
            n.tx_bits = r.tx_bits - 4'h1;
            n.txd     = r.tx_sh[1];
            if (r.tx_bits == 4'h2) begin
              n.ti = 1'b1;
            end
            if (r.tx_bits == 4'h1) begin
              n.tx_st = TX_IDLE;
              n.txd   = 1'b1;
            end
          end
        end
      end
      TX_SHIFT: begin
        if (r.m0_rx && !r.ren) begin
          n.tx_st = TX_IDLE;
          n.txd   = 1'b1;
        end else if (m0_tick) begin
          n.tx_cnt = r.tx_cnt + 4'h1;
          if (r.tx_cnt == m0_lim) begin
            n.tx_cnt = 4'h0;
            n.m0_hi  = ~r.m0_hi;
            if (!r.m0_hi) begin
              // Rising clock edge: the far end samples, we sample
              n.txd = 1'b1;
              if (r.m0_rx) begin
                n.tx_sh[7:0] = {rxd_s, r.tx_sh[7:1]};
              end
            end else begin
              n.txd     = 1'b0;
              n.tx_bits = r.tx_bits - 4'h1;
              if (!r.m0_rx) begin
                n.tx_sh[7:0] = {1'b1, r.tx_sh[7:1]};
                n.rxd_out    = r.tx_sh[1];
              end
              if (r.tx_bits == 4'h1) begin
                n.tx_st    = TX_IDLE;
                n.txd      = 1'b1;
                n.rxd_out  = 1'b1;
                n.rxd_oe_n = 1'b1;
                if (r.m0_rx) begin
                  n.ri     = 1'b1;
                  n.rx_buf = r.tx_sh[7:0];
                end else begin
                  n.ti = 1'b1;
                end
              end
            end
          end
        end
      end
      default: begin
        n.tx_st = TX_IDLE;
      end
    endcase

    // ----------------------------------------------------------------
    // Asynchronous receiver
    // ----------------------------------------------------------------
    n.rxd_prev = rxd_s;
    rx_last    = (mode != MODE_UART8 && r.feacc) ? RX_LAST_LONG : RX_LAST_SHORT;
    stop_b     = (mode == MODE_UART8) ? r.rx_sh[8] : r.rx_sh[9];
    addr_ok    = (((r.rx_sh[7:0] ^ r.slave_address) & r.slave_address_mask) == 8'h00);
    if (mode == MODE_UART8) begin
      accept = !r.ri && (!r.mpe || stop_b);
    end else begin
      accept = !r.ri && (!r.mpe || (r.rx_sh[8] && addr_ok));
    end
    if (!r.ren || m0) begin
      n.rx_st = RX_IDLE;
    end else begin
      case (r.rx_st)
        RX_IDLE: begin
          n.rx_cnt = 4'h0;
          if (r.rxd_prev && !rxd_s) begin
            n.rx_st = RX_START;
          end
        end
        RX_START: begin
          if (rx_smp) begin
            n.rx_cnt = r.rx_cnt + 4'h1;
            if (r.rx_cnt == SMP_MID) begin
              // A glitch shorter than half a bit is not a start
              n.rx_st   = rxd_s ? RX_IDLE : RX_BITS;
              n.rx_cnt  = 4'h0;
              n.rx_bits = 4'h0;
            end
          end
        end
        RX_BITS: begin
          if (rx_smp) begin
            n.rx_cnt = r.rx_cnt + 4'h1;
            if (r.rx_cnt == SMP_LAST) begin
              n.rx_sh[r.rx_bits] = rxd_s;
              n.rx_bits          = r.rx_bits + 4'h1;
              if (r.rx_bits == rx_last) begin
                n.rx_st = RX_DONE;
              end
            end
          end
        end
        RX_DONE: begin
          n.rx_st = RX_IDLE;
          if (r.feacc && !stop_b) begin
            n.fe = 1'b1;
          end
          if (accept) begin
            n.ri     = 1'b1;
            n.rx_buf = r.rx_sh[7:0];
            n.rb8    = (mode == MODE_UART8) ? stop_b : r.rx_sh[8];
          end
        end
        default: begin
          n.rx_st = RX_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      {r.sm0, r.sm1, r.mpe, r.ren, r.tb8, r.rb8, r.ti, r.ri} <= SERIAL_CONTROL_RST;
      r.rx_buf   <= SERIAL_BUFFER_RST;
      r.baud_reload      <= BAUD_RELOAD_RST;
      r.bc       <= BAUD_CONTROL_RST;
      {r.dbl, r.feacc} <= POWER_CONTROL_RST;
      r.slave_address    <= SLAVE_ADDRESS_RST;
      r.slave_address_mask    <= SLAVE_ADDRESS_MASK_RST;
      r.tx_st    <= TX_IDLE;
      r.rx_st    <= RX_IDLE;
      r.txd      <= 1'b1;
      r.rxd_out  <= 1'b1;
      r.rxd_oe_n <= 1'b1;
      r.rxd_prev <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register
  assign apb_rsp  = r.rsp;
  assign txd      = r.txd;
  assign rxd_out  = r.rxd_out;
  assign rxd_oe_n = r.rxd_oe_n;

endmodule : usp_uart
`default_nettype wire

// ---- tb/usp_uart_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------
// Bus and shift clock checks
// ----------
module usp_uart_checker (
  // Clock and reset
  input wire logic                  pclk,
  input wire logic                  presetn,
  // Register bus
  input wire usp_pkg::usp_apb_req_t apb_req,
  input wire usp_pkg::usp_apb_rsp_t apb_rsp,
  // Lines
  input wire logic                  t1_ovf,
  input wire logic                  txd,
  input wire logic                  rxd_in,
  input wire logic                  rxd_out,
  input wire logic                  rxd_oe_n
);
  import usp_pkg::*;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic       setup;
  logic [7:0] idx;
  logic       mapped;
  // Decode of a request in its setup cycle
  assign setup  = apb_req.psel && !apb_req.penable;
  assign idx    = apb_req.paddr[9:2];
  assign mapped = apb_req.paddr[11:10] == 2'b00 && apb_req.paddr[1:0] == 2'b00
    && idx inside {IDX_SERIAL_CONTROL, IDX_SERIAL_BUFFER, IDX_BAUD_RELOAD,
    IDX_BAUD_CONTROL, IDX_POWER_CONTROL, IDX_SLAVE_ADDRESS, IDX_SLAVE_ADDRESS_MASK};
  a_ready_next: assert property (setup |=> apb_rsp.pready)
    else $error("no ready after setup");
  a_ready_single: assert property (apb_rsp.pready |-> ##1 !apb_rsp.pready)
    else $error("ready held too long");
  a_err_unmapped: assert property (setup && !mapped |=> apb_rsp.pslverr)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (setup && mapped |=> !apb_rsp.pslverr)
    else $error("mapped access refused");
  a_read_upper: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_resv_zero: assert property (setup && mapped && !apb_req.pwrite
    && idx == IDX_BAUD_CONTROL |=> apb_rsp.prdata[7:5] == 3'b000)
    else $error("reserved baud bits not zero");
  // Limitation: assumes the divide-by-six shift source
  a_shift_low: assert property (!rxd_oe_n && $fell(txd) |-> !txd [*3] ##1 txd)
    else $error("shift clock low half wrong");
  a_shift_high: assert property (!rxd_oe_n && $rose(txd) |-> txd [*3])
    else $error("shift clock high half short");
  a_shift_drive: assert property ($fell(rxd_oe_n) |-> !rxd_oe_n [*8])
    else $error("shift drive too short");
endmodule : usp_uart_checker

bind usp_uart usp_uart_checker chk_u (.pclk, .presetn, .apb_req, .apb_rsp, .t1_ovf,
  .txd, .rxd_in, .rxd_out, .rxd_oe_n);
`default_nettype wire

// ---- tb/usp_remote.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------
// Remote serial device at the far end
// ----------
module usp_remote (
  // Clock
  input wire logic pclk,
  // Lines
  input wire logic txd,
  output logic     rxd
);
  int          per = 16;
  int          nb  = 11;
  logic [10:0] q[$];
  logic [10:0] f;
  // Idle line stays high, as a pulled-up wire would
  initial rxd = 1'b1;
  // Start bit, data LSB first, ninth, stop
  task automatic send(input logic [10:0] fr);
    for (int i = 0; i < nb; i++) begin
      rxd <= fr[i];
      repeat (per) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask : send
  // Capture at mid bit, on the falling clock edge to avoid races
  always begin
    @(negedge txd);
    f = '0;
    repeat (per / 2) @(negedge pclk);
    for (int i = 0; i < nb; i++) begin
      f[i] = txd;
      repeat (per) @(negedge pclk);
    end
    q.push_back(f);
  end
endmodule : usp_remote
`default_nettype wire

// ---- tb/usp_uart_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module usp_uart_tb;
  import usp_pkg::*;
  // ----------
  // Signals
  // ----------
  logic         pclk, presetn, t1_ovf, t1_on, txd, rxd_out, rxd_oe_n, rem_rxd, err;
  usp_apb_req_t req;
  usp_apb_rsp_t rsp;
  int           errors, cmp_count;
  logic [31:0]  lfsr, rd;
  logic [7:0]   b, got;
  wire logic    pin = rxd_oe_n ? rem_rxd : rxd_out;  // Shared receive pin
  usp_uart dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .t1_ovf(t1_ovf), .txd(txd), .rxd_in(pin), .rxd_out(rxd_out), .rxd_oe_n(rxd_oe_n));
  usp_remote rem_u (.pclk(pclk), .txd(txd), .rxd(rem_rxd));
  // Clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Timer 1 overflow every second cycle once enabled
  always @(posedge pclk) t1_ovf <= t1_on && !t1_ovf;
  // ----------
  // Tasks
  // ----------
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt
  // Expected frame, bit 0 first
  function automatic logic [10:0] frm(input logic [7:0] d, input logic n9, st, input int n);
    frm = (n == 10) ? {1'b0, st, d, 1'b0} : {st, n9, d, 1'b0};
  endfunction : frm
  task automatic chk(input logic [31:0] g, e, input string s);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk
  // Setup, then access held until ready
  task automatic bus(input logic w, input logic [7:0] i, d);
    int n;
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= w;
    req.paddr   <= {2'b00, i, 2'b00};
    req.pwdata  <= {24'h0, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd  = rsp.prdata;
    err = rsp.pslverr;
    chk({31'h0, rsp.pready}, 32'h1, "ready");
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);  // Idle edge between transfers
  endtask : bus
  task automatic rdc(input logic [7:0] i, m, e);
    bus(1'b0, i, 8'h00);
    chk(rd & {24'h0, m}, {24'h0, e}, "reg");
  endtask : rdc
  task automatic cfg(input logic [7:0] sc, pc, bc, input int p, n);
    bus(1'b1, IDX_POWER_CONTROL, pc);
    bus(1'b1, IDX_BAUD_CONTROL, bc);
    repeat (300) @(posedge pclk);  // Generator may start far from overflow
    bus(1'b1, IDX_SERIAL_CONTROL, sc);
    rem_u.per = p;
    rem_u.nb  = n;
    lfsr = nxt(lfsr);
    b    = lfsr[7:0];
  endtask : cfg
  task automatic tx(input logic n9);
    int n;
    bus(1'b1, IDX_SERIAL_BUFFER, b);
    n = 0;
    while (rem_u.q.size() == 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(rem_u.q.pop_front()), 32'(frm(b, n9, 1'b1, rem_u.nb)), "frame");
  endtask : tx
  task automatic rx(input logic n9, st);
    rem_u.send(frm(b, n9, st, rem_u.nb));
    repeat (8) @(posedge pclk);
  endtask : rx
  task automatic summarize();
    if (errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : summarize
  // Watchdog over the whole run
  initial begin
    #200000;
    errors++;
    summarize();
  end
  // ----------
  // Scenarios
  // ----------
  initial begin
    req = '0;
    presetn = 1'b0;
    t1_on = 1'b0;
    t1_ovf = 1'b0;
    errors = 0;
    cmp_count = 0;
    lfsr = 32'h8357c4d8;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 7; i++) begin
      rdc(i < 5 ? 8'h98 + 8'(i) : (i == 5 ? 8'ha9 : 8'hb9), 8'hff, 8'h00);
    end
    bus(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1, "slverr");
    bus(1'b1, IDX_BAUD_RELOAD, 8'hff);
    rdc(IDX_BAUD_RELOAD, 8'hff, 8'hff);
    cfg(8'h98, 8'h80, 8'h00, 16, 11);
    tx(1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h82, 8'h82);
    rx(1'b0, 1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h05, 8'h01);
    rdc(IDX_SERIAL_BUFFER, 8'hff, b);
    cfg(8'h50, 8'h80, 8'h1e, 16, 10);
    tx(1'b0);
    rx(1'b0, 1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h05, 8'h05);
    rdc(IDX_SERIAL_BUFFER, 8'hff, b);
    t1_on <= 1'b1;
    cfg(8'h50, 8'h80, 8'h00, 32, 10);
    tx(1'b0);
    rx(1'b0, 1'b1);
    rdc(IDX_SERIAL_BUFFER, 8'hff, b);
    cfg(8'h50, 8'h80, 8'h1c, 96, 10);
    tx(1'b0);
    cfg(8'h50, 8'h80, 8'h0e, 16, 10);
    bus(1'b1, IDX_SERIAL_BUFFER, b);
    repeat (300) @(posedge pclk);
    rdc(IDX_SERIAL_CONTROL, 8'h02, 8'h00);
    bus(1'b1, IDX_BAUD_CONTROL, 8'h1e);
    repeat (400) @(posedge pclk);
    rdc(IDX_SERIAL_CONTROL, 8'h02, 8'h02);
    rem_u.q.delete();
    cfg(8'h50, 8'hc0, 8'h1e, 16, 10);
    rx(1'b0, 1'b0);
    rdc(IDX_SERIAL_CONTROL, 8'h81, 8'h81);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'hd0);
    rx(1'b0, 1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h81, 8'h81);
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h50);
    rdc(IDX_SERIAL_CONTROL, 8'h80, 8'h00);
    cfg(8'h40, 8'h80, 8'h1e, 16, 10);
    rx(1'b0, 1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h01, 8'h00);
    bus(1'b1, IDX_SLAVE_ADDRESS, 8'h5a);
    bus(1'b1, IDX_SLAVE_ADDRESS_MASK, 8'hf0);
    cfg(8'hf0, 8'h80, 8'h1e, 16, 11);
    b = 8'h35;
    rx(1'b1, 1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h01, 8'h00);
    b = 8'h53;
    rx(1'b1, 1'b1);
    rdc(IDX_SERIAL_CONTROL, 8'h05, 8'h05);
    cfg(8'h00, 8'h80, 8'h00, 16, 11);
    bus(1'b1, IDX_SERIAL_BUFFER, b);
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      got[i] = rxd_out;
    end
    chk({24'h0, got}, {24'h0, b}, "shift");
    repeat (20) @(posedge pclk);
    rdc(IDX_SERIAL_CONTROL, 8'h02, 8'h02);
    // Mode 0 receive: new bit at each shift clock fall
    rem_u.rxd <= b[0];
    bus(1'b1, IDX_SERIAL_CONTROL, 8'h10);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      rem_u.rxd <= b[i];
    end
    repeat (20) @(posedge pclk);
    rdc(IDX_SERIAL_CONTROL, 8'h03, 8'h01);
    rdc(IDX_SERIAL_BUFFER, 8'hff, b);
    summarize();
  end
endmodule : usp_uart_tb
`default_nettype wire
